// >>> dsss_framer.sv
// DSSS transmit framer (preamble, delimiter, header, scrambler, DPSK
// coder, Barker spreader) with receive header checker, AHB-Lite slave.
// Assumes a 100 MHz clock; receive bits come from on-chip demod logic
// on this clock; power enables and transmit data are pins.
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dsss_framer_defines.svh"
module dsss_framer (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic      [31:0]          hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  input  wire logic                 transmit_power_enable_i,
  input  wire logic                 receive_power_enable_i,
  input  wire logic                 tx_data_i,
  output logic                      tx_data_req_o,
  output dsss_framer_pkg::iq_t      tx_iq_o,
  input  wire logic                 rx_bit_i,
  input  wire logic                 rx_bit_valid_i,
  input  wire logic                 pn_acquired_i,
  output logic                      header_valid_ready_o,
  output logic                      rx_short_o,
  output logic      [1:0]           rx_rate_sel_o,
  output logic                      rx_rotate_rev_o
);
  import dsss_framer_pkg::*;

  // Pin synchronisers: a change counts once stages two and three agree
  logic [2:0] tpe_s, rpe_s, tdat_s;
  logic       tpe, rpe, tdat;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tpe_s  <= 3'h0;
      rpe_s  <= 3'h0;
      tdat_s <= 3'h0;
      tpe    <= 1'b0;
      rpe    <= 1'b0;
      tdat   <= 1'b0;
    end else begin
      tpe_s  <= {tpe_s[1:0], transmit_power_enable_i};
      rpe_s  <= {rpe_s[1:0], receive_power_enable_i};
      tdat_s <= {tdat_s[1:0], tx_data_i};
      if (tpe_s[1] == tpe_s[2]) tpe <= tpe_s[2];
      if (rpe_s[1] == rpe_s[2]) rpe <= rpe_s[2];
      if (tdat_s[1] == tdat_s[2]) tdat <= tdat_s[2];
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  wire       ap_sel = hsel_i & htrans_i[1] & hready_i;
  wire       ap_hit = haddr_i[31:8] == 24'h0;
  wire [5:0] ap_idx = haddr_i[7:2];
  logic      wr_q;
  logic [5:0] wa_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      wa_q <= 6'h0;
    end else if (hready_i) begin
      wr_q <= ap_sel & hwrite_i & ap_hit;
      wa_q <= ap_idx;
    end
  end
  wire [7:0] wd = hwdata_i[7:0];
  wire we_sl  = wr_q & (wa_q == `ADDR_SHORT_LEN);
  wire we_ll  = wr_q & (wa_q == `ADDR_LONG_LEN);
  wire we_su  = wr_q & (wa_q == `ADDR_TX_SETUP);
  wire we_sv  = wr_q & (wa_q == `ADDR_SERVICE);
  wire we_lh  = wr_q & (wa_q == `ADDR_LEN_HIGH);
  wire we_lo  = wr_q & (wa_q == `ADDR_LEN_LOW);
  wire we_ro  = wr_q & (wa_q == `ADDR_ROTATION);
  wire we_sc  = wr_q & (wa_q == `ADDR_SCRAMBLER);
  wire we_ls  = wr_q & (wa_q == `ADDR_LONG_SEED);
  wire we_ss  = wr_q & (wa_q == `ADDR_SHORT_SEED);
  wire we_rs  = wr_q & (wa_q == `ADDR_RX_STATUS);

  logic [7:0] short_preamble_length, long_preamble_length, tx_setup;
  logic [7:0] service_field_value, tx_length_high, tx_length_low;
  logic [7:0] rotation_control_reg, scrambler_control_reg;
  logic [7:0] long_seed_reg, short_seed_reg, receive_status_reg;
  logic [7:0] rxs_next, rd_next;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      short_preamble_length <= `SHORT_LEN_RST;
      long_preamble_length  <= `LONG_LEN_RST;
      tx_setup              <= `ZERO_RST;
      service_field_value   <= `ZERO_RST;
      tx_length_high        <= `ZERO_RST;
      tx_length_low         <= `ZERO_RST;
      rotation_control_reg  <= `ZERO_RST;
      scrambler_control_reg <= `ZERO_RST;
      long_seed_reg         <= `SEED_RST;
      short_seed_reg        <= `SEED_RST;
      receive_status_reg    <= `ZERO_RST;
    end else begin
      if (we_sl) short_preamble_length <= wd;
      if (we_ll) long_preamble_length  <= wd;
      if (we_su) tx_setup              <= wd;
      if (we_sv) service_field_value   <= wd;
      if (we_lh) tx_length_high        <= wd;
      if (we_lo) tx_length_low         <= wd;
      if (we_ro) rotation_control_reg  <= wd;
      if (we_sc) scrambler_control_reg <= wd;
      if (we_ls) long_seed_reg         <= wd;
      if (we_ss) short_seed_reg        <= wd;
      receive_status_reg <= rxs_next;
    end
  end

  // Transmit timing: 100 cycles per symbol, 11 chips spread evenly
  logic [6:0] sym_cnt, acc;
  logic [3:0] chip;
  wire        sym_end = sym_cnt == 7'(`SYM_CYCLES - 1);
  wire        sym_mid = sym_cnt == 7'(`SYM_CYCLES / 2 - 1);
  wire  [6:0] acc_sum = acc + 7'(`CHIPS_PER_SYM);
  wire        chip_adv = acc_sum >= 7'(`SYM_CYCLES);
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sym_cnt <= 7'h00;
      acc     <= 7'h00;
      chip    <= 4'h0;
    end else if (sym_end) begin
      sym_cnt <= 7'h00;
      acc     <= 7'h00;
      chip    <= 4'h0;
    end else begin
      sym_cnt <= sym_cnt + 7'h01;
      acc     <= chip_adv ? acc_sum - 7'(`SYM_CYCLES) : acc_sum;
      if (chip_adv) chip <= chip + 4'h1;
    end
  end

  // Transmit framing
  tx_state_t  st, st_next;
  logic       short_q, hold0, raw;
  logic [7:0] plen_q, svc_q;
  logic [1:0] rate_q, phase;
  logic [15:0] len_q, bit_cnt, sym_in, crc;
  logic [6:0] scr;
  wire [15:0] sfd_long = `SFD_LONG;
  logic [15:0] sfd_short;
  for (genvar k = 0; k < 16; k++) begin : g_rev
    assign sfd_short[k] = sfd_long[15-k];
  end
  wire [7:0] rate_field = (rate_q == 2'b00) ? `RATE_1M :
                          (rate_q == 2'b01) ? `RATE_2M :
                          (rate_q == 2'b10) ? `RATE_5M5 : `RATE_11M;
  wire [31:0] hdr_word = {len_q, svc_q, rate_field};
  wire active  = (st != TX_IDLE) & (st != TX_DONE);
  // CCK rates are carried as dibits; their coding lives elsewhere
  wire dual    = (st == TX_HDR & short_q) |
                 (st == TX_DATA & rate_q != 2'b00);
  wire slot    = active & (sym_end | (dual & sym_mid));
  wire byp_tx  = scrambler_control_reg[`SCR_BYPASS_BIT];
  wire scr_bit = byp_tx ? raw : raw ^ scr[3] ^ scr[6];
  wire [1:0] delta = dual ? {hold0, hold0 ^ scr_bit}
                          : {scr_bit, 1'b0};
  wire rot_tx  = rotation_control_reg[`ROT_TX_BIT];
  wire [1:0] dphase = rot_tx ? 2'(-delta) : delta;
  wire start   = (st == TX_IDLE) & (st_next == TX_SYNC);
  wire in_crc  = bit_cnt < `HDR_CRC_BIT;
  wire crc_fb  = crc[15] ^ raw;
  wire [15:0] sym_nx = sym_in + 16'h0001;
  wire [10:0] barker = `BARKER_WORD;

  always_comb begin
    case (st)
      TX_SYNC: raw = ~short_q;
      TX_SFD:  raw = short_q ? sfd_short[bit_cnt[3:0]]
                             : sfd_long[bit_cnt[3:0]];
      TX_HDR:  raw = in_crc ? hdr_word[bit_cnt[4:0]] : ~crc[15];
      TX_DATA: raw = tdat;
      default: raw = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st;
    if (!tpe) st_next = TX_IDLE;
    else if (sym_end) begin
      case (st)
        TX_IDLE: st_next = TX_SYNC;
        TX_SYNC: if (sym_nx >= {8'h00, plen_q}) st_next = TX_SFD;
        TX_SFD:  if (sym_in == `SFD_SYMS) st_next = TX_HDR;
        TX_HDR:  if (bit_cnt == `HDR_LAST_BIT)
                   st_next = (len_q == 16'h0) ? TX_TAIL : TX_DATA;
        TX_DATA: if (sym_nx >= len_q) st_next = TX_TAIL;
        TX_TAIL: if (sym_nx == `DUMMY_SYMS) st_next = TX_DONE;
        // Holds until the controller drops its enable
        TX_DONE: st_next = TX_DONE;
        default: st_next = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st      <= TX_IDLE;
      bit_cnt <= 16'h0;
      sym_in  <= 16'h0;
    end else begin
      st      <= st_next;
      bit_cnt <= (st_next != st) ? 16'h0 : bit_cnt + {15'h0, slot};
      sym_in  <= (st_next != st) ? 16'h0 : sym_in + {15'h0, sym_end};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      short_q <= 1'b0;
      plen_q  <= 8'h00;
      svc_q   <= 8'h00;
      rate_q  <= 2'b00;
      len_q   <= 16'h0;
    end else if (start) begin
      short_q <= tx_setup[`SETUP_SHORT_BIT];
      plen_q  <= tx_setup[`SETUP_SHORT_BIT] ? short_preamble_length
                                            : long_preamble_length;
      svc_q   <= service_field_value;
      rate_q  <= tx_setup[1:0];
      len_q   <= {tx_length_high, tx_length_low};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scr   <= 7'h00;
      crc   <= `CRC_PRESET;
      phase <= 2'b00;
      hold0 <= 1'b0;
    end else if (start) begin
      scr   <= tx_setup[`SETUP_SHORT_BIT] ? short_seed_reg[6:0]
                                          : long_seed_reg[6:0];
      crc   <= `CRC_PRESET;
      phase <= 2'b00;
    end else if (slot) begin
      scr <= {scr[5:0], scr_bit};
      if (st == TX_HDR)
        crc <= in_crc ? ({crc[14:0], 1'b0} ^ (crc_fb ? `CRC_POLY : 16'h0))
                      : {crc[14:0], 1'b1};
      if (sym_end) phase <= phase + dphase;
      else hold0 <= scr_bit;
    end
  end

  // Phase quadrant to I/Q sign bits, then chip-rate Barker spreading
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_iq_o       <= '0;
      tx_data_req_o <= 1'b0;
    end else begin
      tx_iq_o.i     <= active & (phase[1] ^ phase[0] ^ barker[chip]);
      tx_iq_o.q     <= active & (phase[1] ^ barker[chip]);
      tx_data_req_o <= slot & (st == TX_DATA);
    end
  end

  // Receive header checker
  rx_state_t  rs;
  logic [8:0] rcnt;
  logic [15:0] rsr, rcrc;
  logic [6:0] dscr;
  logic [7:0] rrate;
  logic       rbad;
  wire byp_rx  = scrambler_control_reg[`SCR_BYPASS_BIT];
  wire dbit    = byp_rx ? rx_bit_i : rx_bit_i ^ dscr[3] ^ dscr[6];
  wire [15:0] rsr_nx = {dbit, rsr[15:1]};
  wire hit_l   = rsr_nx == sfd_long;
  wire hit_s   = rsr_nx == sfd_short;
  wire rv      = rx_bit_valid_i;
  wire r_in_crc = rcnt < 9'(`HDR_CRC_BIT);
  wire rmis    = dbit != ~rcrc[15];
  wire rlast   = rv & (rs == RX_HDR) & (rcnt == 9'(`HDR_LAST_BIT));
  wire crc_err = rlast & (rbad | rmis);
  wire sfd_to  = rv & (rs == RX_SFD) & ~hit_l & ~hit_s &
                 (rcnt == `SFD_TIMEOUT_BITS);
  wire rlost   = ~rpe | ~pn_acquired_i;
  wire [7:0] rset = ({7'h0, crc_err} << `RXS_CRC_ERR_BIT) |
                    ({7'h0, sfd_to} << `RXS_TIMEOUT_BIT);
  wire [7:0] rclr = we_rs ? wd : 8'h00;
  wire [7:0] rlive = ({7'h0, header_valid_ready_o} << `RXS_VALID_BIT) |
                     ({7'h0, rx_short_o} << `RXS_SHORT_BIT);
  // Set beats a same-cycle write-one clear
  assign rxs_next = (((receive_status_reg & ~rclr) | rset) & 8'h0C) | rlive;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rs   <= RX_ACQ;
      rcnt <= 9'h0;
      rsr  <= 16'h0;
      rcrc <= `CRC_PRESET;
      dscr <= 7'h00;
      rrate <= 8'h00;
      rbad <= 1'b0;
      rx_short_o <= 1'b0;
      header_valid_ready_o <= 1'b0;
    end else if (rs != RX_ACQ && rlost) begin
      rs   <= RX_ACQ;
      header_valid_ready_o <= 1'b0;
    end else begin
      if (rv) dscr <= {dscr[5:0], rx_bit_i};
      case (rs)
        RX_ACQ: if (!rlost) begin
          rs   <= RX_INIT;
          rcnt <= 9'h0;
        end
        RX_INIT: if (rv) begin
          rcnt <= (rcnt == `DESCR_INIT_LAST) ? 9'h0 : rcnt + 9'h1;
          if (rcnt == `DESCR_INIT_LAST) rs <= RX_SFD;
        end
        RX_SFD: if (rv) begin
          rsr  <= rsr_nx;
          rcnt <= rcnt + 9'h1;
          if (hit_l | hit_s) begin
            rs   <= RX_HDR;
            rx_short_o <= hit_s;
            rcnt <= 9'h0;
            rcrc <= `CRC_PRESET;
            rbad <= 1'b0;
          end else if (sfd_to) rs <= RX_ACQ;
        end
        RX_HDR: if (rv) begin
          rcnt <= rcnt + 9'h1;
          if (rcnt < 9'h8) rrate <= {dbit, rrate[7:1]};
          if (r_in_crc)
            rcrc <= {rcrc[14:0], 1'b0} ^
                    ((rcrc[15] ^ dbit) ? `CRC_POLY : 16'h0);
          else begin
            rcrc <= {rcrc[14:0], 1'b1};
            rbad <= rbad | rmis;
          end
          if (rlast) begin
            rs <= crc_err ? RX_ACQ : RX_PAY;
            header_valid_ready_o <= ~crc_err;
          end
        end
        RX_PAY: rs <= RX_PAY;
        default: rs <= RX_ACQ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_rate_sel_o   <= 2'b00;
      rx_rotate_rev_o <= 1'b0;
    end else begin
      rx_rotate_rev_o <= rotation_control_reg[`ROT_RX_BIT];
      rx_rate_sel_o   <= (rrate == `RATE_2M)  ? 2'b01 :
                         (rrate == `RATE_5M5) ? 2'b10 :
                         (rrate == `RATE_11M) ? 2'b11 : 2'b00;
    end
  end

  always_comb begin
    case (ap_idx)
      `ADDR_SHORT_LEN:  rd_next = short_preamble_length;
      `ADDR_LONG_LEN:   rd_next = long_preamble_length;
      `ADDR_TX_SETUP:   rd_next = tx_setup;
      `ADDR_SERVICE:    rd_next = service_field_value;
      `ADDR_LEN_HIGH:   rd_next = tx_length_high;
      `ADDR_LEN_LOW:    rd_next = tx_length_low;
      `ADDR_ROTATION:   rd_next = rotation_control_reg;
      `ADDR_SCRAMBLER:  rd_next = scrambler_control_reg;
      `ADDR_LONG_SEED:  rd_next = long_seed_reg;
      `ADDR_SHORT_SEED: rd_next = short_seed_reg;
      `ADDR_RX_STATUS:  rd_next = receive_status_reg;
      `ADDR_TX_STATUS:  rd_next = {4'h0, active, st};
      default:          rd_next = 8'h00;
    endcase
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (ap_sel & ~hwrite_i) begin
      hrdata_o <= ap_hit ? {24'h0, rd_next} : 32'h0;
    end
  end

  // Checks
  logic [15:0] pre_syms;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pre_syms <= 16'h0;
    else if (st == TX_IDLE) pre_syms <= 16'h0;
    else if (sym_end) pre_syms <= pre_syms + 16'h1;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_long_sync_ones: assert property (
    st == TX_SYNC && !short_q |-> raw == 1'b1) else $error("sync not ones");
  chk_short_sync_zero: assert property (
    st == TX_SYNC && short_q |-> raw == 1'b0) else $error("sync not zeros");
  chk_preamble_dbpsk: assert property (
    (st == TX_SYNC || st == TX_SFD) |-> !dual) else $error("preamble rate");
  chk_hdr_duration: assert property (
    st == TX_HDR && st_next != TX_HDR && tpe |=> pre_syms ==
    (short_q ? {8'h0, plen_q} + 16'd40 : {8'h0, plen_q} + 16'd64))
    else $error("preamble and header duration wrong");
  chk_short_sfd_rev: assert property (
    st == TX_SFD && short_q |-> raw == sfd_long[4'hF - bit_cnt[3:0]])
    else $error("short delimiter not reversed");
  chk_crc_error: assert property (
    crc_err |=> rs == RX_ACQ && !header_valid_ready_o &&
    receive_status_reg[`RXS_CRC_ERR_BIT]) else $error("crc error path");
  chk_ready_after_hdr: assert property (
    $rose(header_valid_ready_o) |-> $past(rs) == RX_HDR)
    else $error("ready without delimiter");
  chk_bypass: assert property (
    slot && byp_tx |-> scr_bit == raw) else $error("bypass not clean");
  chk_long_iq_same: assert property (
    (st == TX_SYNC || st == TX_SFD || st == TX_HDR) && !short_q
    |=> tx_iq_o.i == tx_iq_o.q) else $error("dbpsk I and Q differ");
  chk_dibit_90: assert property (
    slot && sym_end && dual && !rot_tx && {hold0, scr_bit} == 2'b01
    |=> phase == $past(phase) + 2'b01) else $error("dibit 01 not +90");
  chk_data_req: assert property (
    slot && st == TX_DATA |=> tx_data_req_o) else $error("no data request");
  cov_long_pkt: cover property (st == TX_DONE && !short_q);
  cov_short_pkt: cover property (st == TX_DONE && short_q);
  cov_rx_good: cover property ($rose(header_valid_ready_o));
  cov_rx_crc: cover property (crc_err);
endmodule
`default_nettype wire

// >>> dsss_framer_defines.svh
// Offsets, field positions, reset values and timing counts of the framer.
// Included by the framer; holds definitions only.
`ifndef DSSS_FRAMER_DEFINES_SVH
`define DSSS_FRAMER_DEFINES_SVH
`define CLK_PERIOD_NS    10
`define SYMBOL_TIME_NS   1000
`define SYM_CYCLES       (`SYMBOL_TIME_NS / `CLK_PERIOD_NS)
`define CHIPS_PER_SYM    11
`define BARKER_WORD      11'h0ED
`define SFD_LONG         16'hF3A0
`define SFD_SYMS         16'h000F
`define HDR_LAST_BIT     16'h002F
`define HDR_CRC_BIT      16'h0020
`define DUMMY_SYMS       16'h0002
`define CRC_POLY         16'h1021
`define CRC_PRESET       16'hFFFF
`define DESCR_INIT_LAST  9'h006
`define SFD_TIMEOUT_BITS 9'h0A0
`define RATE_1M          8'h0A
`define RATE_2M          8'h14
`define RATE_5M5         8'h37
`define RATE_11M         8'h6E
`define ADDR_SHORT_LEN   6'h00
`define ADDR_LONG_LEN    6'h01
`define ADDR_TX_SETUP    6'h02
`define ADDR_SERVICE     6'h03
`define ADDR_LEN_HIGH    6'h04
`define ADDR_LEN_LOW     6'h05
`define ADDR_ROTATION    6'h06
`define ADDR_SCRAMBLER   6'h07
`define ADDR_LONG_SEED   6'h08
`define ADDR_SHORT_SEED  6'h09
`define ADDR_RX_STATUS   6'h0A
`define ADDR_TX_STATUS   6'h0B
`define SHORT_LEN_RST    8'h38
`define LONG_LEN_RST     8'h80
`define SEED_RST         8'h7F
`define ZERO_RST         8'h00
`define SETUP_SHORT_BIT  2
`define ROT_TX_BIT       6
`define ROT_RX_BIT       7
`define SCR_BYPASS_BIT   2
`define RXS_VALID_BIT    0
`define RXS_SHORT_BIT    1
`define RXS_CRC_ERR_BIT  2
`define RXS_TIMEOUT_BIT  3
`endif

// >>> dsss_framer_pkg.sv
// Types shared by the framer and its bench.
// No constants here; those live in the defines header.
package dsss_framer_pkg;
  typedef struct packed {
    logic i;
    logic q;
  } iq_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_SYNC = 3'b001,
    TX_SFD  = 3'b010,
    TX_HDR  = 3'b011,
    TX_DATA = 3'b100,
    TX_TAIL = 3'b101,
    TX_DONE = 3'b110
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_ACQ  = 3'b000,
    RX_INIT = 3'b001,
    RX_SFD  = 3'b010,
    RX_HDR  = 3'b011,
    RX_PAY  = 3'b100
  } rx_state_t;
endpackage

// >>> mac_model.sv
// Controller model: raises transmit enable, feeds payload bits on request.
// Assumes chip outputs rest at 0/0 once the framer has sent its tail.
`timescale 1ns/1ps
`default_nettype none
module mac_model (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 go_i,
  input  wire logic                 tx_data_req_i,
  input  wire dsss_framer_pkg::iq_t tx_iq_i,
  output logic                      tx_en_o,
  output logic                      tx_data_o,
  output logic                      done_o,
  output logic      [15:0]          bits_o
);
  import dsss_framer_pkg::*;
  logic [7:0] idle_reg;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {tx_en_o, tx_data_o, done_o, bits_o, idle_reg} <= '0;
    end else begin
      done_o <= 1'b0;
      idle_reg <= (tx_en_o && tx_iq_i == 2'b00) ? idle_reg + 8'h01 : 8'h00;
      if (go_i) begin
        tx_en_o <= 1'b1;
        bits_o  <= 16'h0000;
      end
      // Barker gaps last 3 chips; 1.5 idle symbols means the tail is out
      if (idle_reg == 8'h95) begin
        tx_en_o <= 1'b0;
        done_o  <= 1'b1;
      end
      if (tx_data_req_i) begin
        bits_o    <= bits_o + 16'h0001;
        tx_data_o <= bits_o[0] ^ bits_o[2];
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_dsss_preamble_header_scrambler_tx.sv
// Self-checking bench for the framer: AHB-Lite master, controller model,
// receive bit source. Assumes a 100 MHz clock and the defines' offsets.
`timescale 1ns/1ps
`default_nettype none
module tb_dsss_preamble_header_scrambler_tx;
  import dsss_framer_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, go = 1'b0, mode1m = 1'b0;
  logic        rxen = 1'b0, rxb = 1'b0, rxv = 1'b0, pna = 1'b0;
  logic [1:0]  htrans = 2'b00, rsel;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_val, d, nt;
  logic        hready, hresp, treq, ten, tdat, done, rdy, rsh, rrev;
  logic [31:0] rates = 32'h6E37140A;
  logic [15:0] bits;
  logic [6:0]  scr = 7'h5A;
  iq_t         iq;
  logic [31:0] notes[$];
  int          num_errors = 0, n_compared = 0, cyc = 0, iqd = 0;
  int          seed = 32'h173cb7ba, ln, n, sym, nsym;
  event        rd_ev;
  always #5 core_clk_i = ~core_clk_i;
  dsss_framer u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .transmit_power_enable_i(ten), .receive_power_enable_i(rxen),
    .tx_data_i(tdat), .tx_data_req_o(treq), .tx_iq_o(iq), .rx_bit_i(rxb),
    .rx_bit_valid_i(rxv), .pn_acquired_i(pna), .header_valid_ready_o(rdy),
    .rx_short_o(rsh), .rx_rate_sel_o(rsel), .rx_rotate_rev_o(rrev));
  mac_model u_mac (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .go_i(go),
    .tx_data_req_i(treq), .tx_iq_i(iq), .tx_en_o(ten), .tx_data_o(tdat),
    .done_o(done), .bits_o(bits));
  task conclude();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge core_clk_i);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, a};
    @(posedge core_clk_i);
    while (hready !== 1'b1) @(posedge core_clk_i);
    {hsel, htrans, hwdata} <= {3'b000, wd};
    @(posedge core_clk_i);
    while (hready !== 1'b1) @(posedge core_clk_i);
    rd_val = hrdata;
    if (!w) -> rd_ev;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    notes.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask
  always begin
    @(rd_ev);
    if (notes.size() > 0) begin
      nt = notes.pop_front();
      check(rd_val, nt);
    end
  end
  task rxbit(input logic b);
    @(posedge core_clk_i);
    rxb <= b ^ scr[3] ^ scr[6];
    rxv <= 1'b1;
    scr <= {scr[5:0], b ^ scr[3] ^ scr[6]};
    @(posedge core_clk_i);
    rxv <= 1'b0;
  endtask
  task rxword(input logic [15:0] w);
    for (int i = 0; i < 16; i++) rxbit(w[i]);
  endtask
  task rxframe(input logic sh, input logic [7:0] rate, input logic bad);
    logic [31:0] h;
    logic [15:0] crc;
    h = $random(seed);
    h[7:0] = rate;
    crc = 16'hFFFF;
    for (int i = 0; i < 32; i++)
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ h[i]) ? 16'h1021 : 16'h0000);
    pna <= 1'b1;
    repeat (2) rxword({16{~sh}});
    rxword(sh ? 16'h05CF : 16'hF3A0);
    rxword(h[15:0]);
    rxword(h[31:16]);
    crc = ~crc ^ {15'h0, bad};
    for (int i = 15; i >= 0; i--) rxbit(crc[i]);
    repeat (3) @(posedge core_clk_i);
  endtask
  always @(posedge core_clk_i) if (mode1m && iq.i !== iq.q) iqd++;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(32'h00, 32'h38);
    rd(32'h04, 32'h80);
    rd(32'h20, 32'h7F);
    rd(32'h24, 32'h7F);
    rd(32'h30, 32'h00);
    for (int a = 12; a <= 20; a += 4) begin
      d = $random(seed);
      ahb(1'b1, 32'(a), d);
      rd(32'(a), {24'h0, d[7:0]});
    end
    ahb(1'b1, 32'h18, 32'h80);
    repeat (2) @(posedge core_clk_i);
    check({31'h0, rrev}, 32'h1);
    ahb(1'b1, 32'h00, 32'h4);
    ahb(1'b1, 32'h04, 32'h4);
    for (int k = 0; k < 2; k++) begin
      ln = 3 + ($random(seed) & 3);
      ahb(1'b1, 32'h10, 32'h0);
      ahb(1'b1, 32'h14, 32'(ln));
      ahb(1'b1, 32'h08, k ? 32'h5 : 32'h0);
      ahb(1'b1, 32'h1C, k ? 32'h4 : 32'h0);
      mode1m <= (k == 0);
      go <= 1'b1;
      @(posedge core_clk_i);
      go <= 1'b0;
      n = 0;
      while (done !== 1'b1) begin
        @(posedge core_clk_i);
        n++;
      end
      mode1m <= 1'b0;
      // Start waits up to a symbol; last tail chips may already read 0/0
      sym = (n - 125) / 100;
      nsym = 4 + 16 + (k ? 24 : 48) + ln + 2;
      check({31'h0, sym >= nsym && sym <= nsym + 1}, 32'h1);
      check({16'h0, bits}, 32'((k + 1) * ln));
      // Enable drop needs the pin synchroniser before the framer idles
      repeat (5) @(posedge core_clk_i);
      rd(32'h2C, 32'h0);
    end
    check(32'(iqd), 32'h0);
    check({31'h0, hresp}, 32'h0);
    ahb(1'b1, 32'h1C, 32'h0);
    rxen <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      rxframe(k[0], rates[8*k +: 8], 1'b0);
      check({31'h0, rdy}, 32'h1);
      check({30'h0, rsel}, 32'(k));
      check({31'h0, rsh}, {31'h0, k[0]});
      rd(32'h28, {30'h0, k[0], 1'b1});
      {rxen, pna} <= (k == 3) ? 2'b00 : 2'b10;
      repeat (3) @(posedge core_clk_i);
      check({31'h0, rdy}, 32'h0);
    end
    rxen <= 1'b1;
    rxframe(1'b0, 8'h0A, 1'b1);
    check({31'h0, rdy}, 32'h0);
    rd(32'h28, 32'h4);
    ahb(1'b1, 32'h28, 32'h4);
    repeat (13) rxword(16'hFFFF);
    ahb(1'b0, 32'h28, 32'h0);
    check({31'h0, rd_val[3]}, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
